// ---- design/nsf_pkg.sv ----
// Shared types and constants for the navigation item formatter
package nsf_pkg;
    typedef enum logic [3:0] {
        IT_LAT, IT_LON, IT_TRK, IT_SPD, IT_DIST, IT_XTK, IT_DTK, IT_BRG,
        IT_VAR, IT_WARN, IT_ALT, IT_UTC, IT_DISC, IT_DDST, IT_TUNE
    } nsf_item_t;

    typedef enum {ST_LOAD, ST_CONV, ST_SEND} nsf_state_t;

    localparam int BIN_W = 24;
    localparam int DIG_N = 7;

    // Field widths, designator excluded
    localparam logic [3:0] W_LAT  = 4'h9;
    localparam logic [3:0] W_LON  = 4'hA;
    localparam logic [3:0] W_3    = 4'h3;
    localparam logic [3:0] W_4    = 4'h4;
    localparam logic [3:0] W_5    = 4'h5;
    localparam logic [3:0] W_6    = 4'h6;
    localparam logic [3:0] W_TUNE = 4'h7;
    localparam logic [3:0] W_UTC  = 4'h8;
    localparam logic [3:0] W_WARN = 4'h9;
    localparam logic [3:0] W_DISC = 4'hA;
    localparam logic [3:0] WARN_POS = 4'h4;

    // Scaling and limits
    localparam logic [23:0] SC_DEG  = 24'h002710;
    localparam logic [23:0] SC_MIN  = 24'h000064;
    localparam logic [15:0] XTK_DIV = 16'h000A;
    localparam logic [9:0]  SPD_MIN = 10'h002;
    localparam logic [11:0] EPE_LIM = 12'h17C;
    localparam logic [12:0] HALF_TURN = 13'h0708;
    localparam logic [12:0] FULL_TURN = 13'h0E10;

    // Characters
    localparam logic [7:0] CH_DASH  = 8'h2D;
    localparam logic [7:0] CH_SP    = 8'h20;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_PLUS  = 8'h2B;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_TWO   = 8'h32;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_I = 8'h49;
    localparam logic [7:0] CH_L = 8'h4C;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_W = 8'h57;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LJ = 8'h6A;
    localparam logic [7:0] CH_LL = 8'h6C;
    localparam logic [7:0] CH_LQ = 8'h71;
    localparam logic [7:0] CH_LT = 8'h74;
endpackage

// ---- design/nsf_cvt_if.sv ----
// Binary to decimal conversion request and result
`timescale 1ns/1ps
`default_nettype none
interface nsf_cvt_if #(
    parameter int BIN_W = 24,
    parameter int DIG_N = 7
);
    logic                   start;
    logic [BIN_W-1:0]       bin;
    logic                   done;
    logic [4*DIG_N-1:0]     bcd;
    modport ctl (output start, output bin, input done, input bcd);
    modport cvt (input start, input bin, output done, output bcd);
endinterface
`default_nettype wire

// ---- design/nsf_bcd_conv.sv ----
// Sequential shift-and-add-three binary to BCD converter
`timescale 1ns/1ps
`default_nettype none
module nsf_bcd_conv #(
    parameter int BIN_W = 24,
    parameter int DIG_N = 7
) (
    input  wire logic clk,
    input  wire logic rst,
    nsf_cvt_if.cvt    cv
);
    localparam int CW = $clog2(BIN_W + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(1);

    logic [BIN_W-1:0]   sh_reg;
    logic [4*DIG_N-1:0] acc_reg;
    logic [4*DIG_N-1:0] adj;
    logic [CW-1:0]      cnt_reg;
    logic               busy_reg;
    logic               done_reg;

    // Add three to every digit above four
    genvar g;
    generate
        for (g = 0; g < DIG_N; g++) begin : g_adj
            assign adj[g*4 +: 4] = (acc_reg[g*4 +: 4] > 4'h4) ?
                                   acc_reg[g*4 +: 4] + 4'h3 :
                                   acc_reg[g*4 +: 4];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            sh_reg   <= '0;
            acc_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg && cv.start) begin
                sh_reg   <= cv.bin;
                acc_reg  <= '0;
                cnt_reg  <= CW'(BIN_W);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                {acc_reg, sh_reg} <= {adj[4*DIG_N-2:0], sh_reg, 1'b0};
                cnt_reg <= cnt_reg - CNT_LAST;
                if (cnt_reg == CNT_LAST) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    assign cv.done = done_reg;
    assign cv.bcd  = acc_reg;
endmodule
`default_nettype wire

// ---- design/nsf_formatter.sv ----
// Navigation data to ASCII serial item formatter
`timescale 1ns/1ps
`default_nettype none
module nsf_formatter (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        enh_mode,
    input  wire logic        pos_flag,
    input  wire logic        nav_flag,
    input  wire logic        lat_south,
    input  wire logic [6:0]  lat_deg,
    input  wire logic [5:0]  lat_min,
    input  wire logic [6:0]  lat_hund,
    input  wire logic        lon_west,
    input  wire logic [7:0]  lon_deg,
    input  wire logic [5:0]  lon_min,
    input  wire logic [6:0]  lon_hund,
    input  wire logic [9:0]  trk_deg,
    input  wire logic [9:0]  ground_speed_value,
    input  wire logic [19:0] dist_tenths,
    input  wire logic        xtk_right,
    input  wire logic [15:0] xtk_milli,
    input  wire logic [11:0] dtk_tenths,
    input  wire logic        course_selector_mode,
    input  wire logic [11:0] sel_course_tenths,
    input  wire logic [11:0] brg_tenths,
    input  wire logic [11:0] radial_tenths,
    input  wire logic        var_west,
    input  wire logic [11:0] var_tenths,
    input  wire logic [11:0] epe_hundredths,
    input  wire logic        alt_valid,
    input  wire logic        alt_neg,
    input  wire logic [16:0] alt_ft,
    input  wire logic [4:0]  utc_hour,
    input  wire logic [5:0]  utc_min,
    input  wire logic [5:0]  utc_sec,
    input  wire logic        wpt_alert,
    input  wire logic        turn_alert,
    input  wire logic        msg_new,
    input  wire logic        msg_persist,
    input  wire logic [1:0]  flight_phase,
    input  wire logic [1:0]  nav_mode,
    input  wire logic        to_flag,
    input  wire logic        from_flag,
    input  wire logic [19:0] dest_tenths,
    input  wire logic        tune_req,
    input  wire logic        voice_radio_target,
    input  wire logic [2:0]  tune_sys,
    input  wire logic [16:0] tune_khz,
    input  wire logic        char_ready,
    output logic      [7:0]  char_data,
    output logic             char_valid,
    output logic             tune_busy
);
    localparam int BW = nsf_pkg::BIN_W;

    nsf_cvt_if #(.BIN_W(BW), .DIG_N(nsf_pkg::DIG_N)) cv ();

    nsf_bcd_conv #(.BIN_W(BW), .DIG_N(nsf_pkg::DIG_N)) u_conv (
        .clk (clk),
        .rst (rst),
        .cv  (cv)
    );

    nsf_pkg::nsf_state_t state_reg;
    nsf_pkg::nsf_item_t  item_reg;
    nsf_pkg::nsf_item_t  ret_reg;
    nsf_pkg::nsf_item_t  nxt;
    logic [3:0]  pos_reg;
    logic [2:0]  dig_reg;
    logic        dash_reg;
    logic [27:0] bcd_reg;
    logic        pend_reg;
    logic        t_voice_reg;
    logic [2:0]  t_sys_reg;
    logic [16:0] t_khz_reg;
    logic [BW-1:0] val;
    logic [3:0]  wid;
    logic [2:0]  ndig;
    logic        dsh;
    logic [7:0]  desig;
    logic [7:0]  ch;
    logic        is_dig;
    logic        ovf;
    logic [12:0] recip_brg;
    logic [27:0] bcd_sh;
    logic [7:0]  dig_ch;
    logic        take;
    logic        last;

    // Reciprocal of the radial, folded into one turn
    always_comb begin
        recip_brg = 13'(radial_tenths) + nsf_pkg::HALF_TURN;
        if (recip_brg >= nsf_pkg::FULL_TURN) begin
            recip_brg = recip_brg - nsf_pkg::FULL_TURN;
        end
    end

    // Per-item value, width, digit count, dash condition, designator
    always_comb begin
        val   = '0;
        wid   = nsf_pkg::W_3;
        ndig  = 3'h3;
        dsh   = 1'b0;
        desig = nsf_pkg::CH_A;
        case (item_reg)
            nsf_pkg::IT_LAT: begin
                val = BW'(lat_deg) * nsf_pkg::SC_DEG
                    + BW'(lat_min) * nsf_pkg::SC_MIN + BW'(lat_hund);
                wid = nsf_pkg::W_LAT;
                ndig = 3'h6;
                dsh = pos_flag;
            end
            nsf_pkg::IT_LON: begin
                val = BW'(lon_deg) * nsf_pkg::SC_DEG
                    + BW'(lon_min) * nsf_pkg::SC_MIN + BW'(lon_hund);
                wid = nsf_pkg::W_LON;
                ndig = 3'h7;
                dsh = pos_flag;
                desig = nsf_pkg::CH_B;
            end
            nsf_pkg::IT_TRK: begin
                val = BW'(trk_deg);
                dsh = pos_flag | (enh_mode &&
                      ground_speed_value < nsf_pkg::SPD_MIN);
                desig = nsf_pkg::CH_C;
            end
            nsf_pkg::IT_SPD: begin
                val = BW'(ground_speed_value);
                dsh = pos_flag;
                desig = nsf_pkg::CH_D;
            end
            nsf_pkg::IT_DIST: begin
                val = BW'(dist_tenths);
                wid = nsf_pkg::W_5;
                ndig = 3'h5;
                dsh = nav_flag;
                desig = nsf_pkg::CH_E;
            end
            nsf_pkg::IT_XTK: begin
                val = enh_mode ? BW'(xtk_milli / nsf_pkg::XTK_DIV)
                               : BW'(xtk_milli);
                wid = nsf_pkg::W_5;
                ndig = 3'h4;
                dsh = nav_flag;
                desig = nsf_pkg::CH_G;
            end
            nsf_pkg::IT_DTK: begin
                val = course_selector_mode ? BW'(sel_course_tenths)
                                           : BW'(dtk_tenths);
                wid = nsf_pkg::W_4;
                ndig = 3'h4;
                dsh = nav_flag;
                desig = nsf_pkg::CH_I;
            end
            nsf_pkg::IT_BRG: begin
                val = course_selector_mode ? BW'(recip_brg)
                                           : BW'(brg_tenths);
                wid = nsf_pkg::W_4;
                ndig = 3'h4;
                dsh = pos_flag;
                desig = nsf_pkg::CH_L;
            end
            nsf_pkg::IT_VAR: begin
                val = BW'(var_tenths);
                wid = nsf_pkg::W_4;
                dsh = pos_flag;
                desig = nsf_pkg::CH_Q;
            end
            nsf_pkg::IT_WARN: begin
                wid = nsf_pkg::W_WARN;
                desig = nsf_pkg::CH_T;
            end
            nsf_pkg::IT_ALT: begin
                val = BW'(alt_ft);
                wid = nsf_pkg::W_6;
                ndig = 3'h5;
                dsh = !alt_valid;
                desig = nsf_pkg::CH_LA;
            end
            nsf_pkg::IT_UTC: begin
                val = BW'(utc_hour) * nsf_pkg::SC_DEG
                    + BW'(utc_min) * nsf_pkg::SC_MIN + BW'(utc_sec);
                wid = nsf_pkg::W_UTC;
                ndig = 3'h6;
                desig = nsf_pkg::CH_LJ;
            end
            nsf_pkg::IT_DISC: begin
                wid = nsf_pkg::W_DISC;
                desig = nsf_pkg::CH_LT;
            end
            nsf_pkg::IT_DDST: begin
                val = BW'(dest_tenths);
                wid = nsf_pkg::W_6;
                ndig = 3'h6;
                dsh = nav_flag;
                desig = nsf_pkg::CH_LL;
            end
            default: begin
                val = BW'(t_khz_reg);
                wid = nsf_pkg::W_TUNE;
                ndig = 3'h5;
                desig = nsf_pkg::CH_LQ;
            end
        endcase
    end

    // Value too wide for its digits
    assign ovf = |(cv.bcd >> {ndig, 2'b00});
    assign bcd_sh = bcd_reg >> {dig_reg, 2'b00};
    assign dig_ch = nsf_pkg::CH_ZERO | {4'h0, bcd_sh[3:0]};

    // Character at the current field position
    always_comb begin
        is_dig = 1'b0;
        ch = nsf_pkg::CH_DASH;
        if (pos_reg == 4'h0) begin
            ch = desig;
        end else if (dash_reg) begin
            ch = nsf_pkg::CH_DASH;
        end else begin
            case (item_reg)
                nsf_pkg::IT_LAT: begin
                    if (pos_reg == 4'h1) begin
                        ch = lat_south ? nsf_pkg::CH_S : nsf_pkg::CH_N;
                    end else if (pos_reg == 4'h2 || pos_reg == 4'h5) begin
                        ch = nsf_pkg::CH_SP;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_LON: begin
                    if (pos_reg == 4'h1) begin
                        ch = lon_west ? nsf_pkg::CH_W : nsf_pkg::CH_E;
                    end else if (pos_reg == 4'h2 || pos_reg == 4'h6) begin
                        ch = nsf_pkg::CH_SP;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_XTK: begin
                    if (pos_reg == 4'h1) begin
                        ch = xtk_right ? nsf_pkg::CH_R : nsf_pkg::CH_L;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_VAR: begin
                    if (pos_reg == 4'h1) begin
                        ch = var_west ? nsf_pkg::CH_W : nsf_pkg::CH_E;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_ALT: begin
                    if (pos_reg == 4'h1) begin
                        ch = alt_neg ? nsf_pkg::CH_DASH : nsf_pkg::CH_PLUS;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_UTC: begin
                    if (pos_reg == 4'h3 || pos_reg == 4'h6) begin
                        ch = nsf_pkg::CH_COLON;
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                nsf_pkg::IT_WARN: begin
                    if (pos_reg == nsf_pkg::WARN_POS &&
                        epe_hundredths > nsf_pkg::EPE_LIM) begin
                        ch = nsf_pkg::CH_A;
                    end
                end
                nsf_pkg::IT_DISC: begin
                    case (pos_reg)
                        4'h1: begin
                            if (wpt_alert) ch = nsf_pkg::CH_W;
                            else if (turn_alert) ch = nsf_pkg::CH_T;
                        end
                        4'h2: begin
                            if (msg_new) ch = nsf_pkg::CH_N;
                            else if (msg_persist) ch = nsf_pkg::CH_P;
                        end
                        4'h3: begin
                            case (flight_phase)
                                2'h0: ch = nsf_pkg::CH_E;
                                2'h1: ch = nsf_pkg::CH_T;
                                2'h2: ch = nsf_pkg::CH_R;
                                default: ch = nsf_pkg::CH_A;
                            endcase
                        end
                        4'h4: begin
                            case (nav_mode)
                                2'h0: ch = nsf_pkg::CH_L;
                                2'h1: ch = nsf_pkg::CH_D;
                                2'h2: ch = nsf_pkg::CH_O;
                                default: ch = nsf_pkg::CH_T;
                            endcase
                        end
                        4'h5: begin
                            if (to_flag) ch = nsf_pkg::CH_T;
                            else if (from_flag) ch = nsf_pkg::CH_F;
                        end
                        default: ch = nsf_pkg::CH_DASH;
                    endcase
                end
                nsf_pkg::IT_TUNE: begin
                    if (pos_reg == 4'h1) begin
                        ch = t_voice_reg ? nsf_pkg::CH_ONE
                                         : nsf_pkg::CH_TWO;
                    end else if (pos_reg == 4'h2) begin
                        ch = nsf_pkg::CH_ZERO | {5'h00, t_sys_reg};
                    end else begin
                        is_dig = 1'b1;
                    end
                end
                default: is_dig = 1'b1;
            endcase
        end
        if (is_dig) begin
            ch = dig_ch;
        end
    end

    assign take = (state_reg == nsf_pkg::ST_SEND) &&
                  (!char_valid || char_ready);
    assign last = take && (pos_reg == wid);
    assign nxt  = (item_reg == nsf_pkg::IT_TUNE) ? ret_reg :
                  (item_reg == nsf_pkg::IT_DDST) ? nsf_pkg::IT_LAT :
                  nsf_pkg::nsf_item_t'(item_reg + 4'h1);
    assign cv.start = (state_reg == nsf_pkg::ST_LOAD);
    assign cv.bin   = val;

    // Item sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= nsf_pkg::ST_LOAD;
            item_reg  <= nsf_pkg::IT_LAT;
            ret_reg   <= nsf_pkg::IT_LAT;
            pos_reg   <= 4'h0;
            dig_reg   <= 3'h0;
            dash_reg  <= 1'b0;
            bcd_reg   <= '0;
        end else begin
            case (state_reg)
                nsf_pkg::ST_LOAD: state_reg <= nsf_pkg::ST_CONV;
                nsf_pkg::ST_CONV: begin
                    if (cv.done) begin
                        bcd_reg   <= cv.bcd;
                        dash_reg  <= dsh | ovf;
                        dig_reg   <= ndig - 3'h1;
                        pos_reg   <= 4'h0;
                        state_reg <= nsf_pkg::ST_SEND;
                    end
                end
                default: begin
                    if (take) begin
                        pos_reg <= pos_reg + 4'h1;
                        if (is_dig) dig_reg <= dig_reg - 3'h1;
                    end
                    if (last) begin
                        state_reg <= nsf_pkg::ST_LOAD;
                        if (pend_reg) begin
                            ret_reg  <= nxt;
                            item_reg <= nsf_pkg::IT_TUNE;
                        end else begin
                            item_reg <= nxt;
                        end
                    end
                end
            endcase
        end
    end

    // Tuning request capture; a new request beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_reg    <= 1'b0;
            t_voice_reg <= 1'b0;
            t_sys_reg   <= 3'h0;
            t_khz_reg   <= '0;
        end else begin
            if (tune_req) begin
                pend_reg    <= 1'b1;
                t_voice_reg <= voice_radio_target;
                t_sys_reg   <= tune_sys;
                t_khz_reg   <= tune_khz;
            end else if (last) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // Output character register
    always_ff @(posedge clk) begin
        if (rst) begin
            char_data  <= nsf_pkg::CH_DASH;
            char_valid <= 1'b0;
        end else if (take) begin
            char_data  <= ch;
            char_valid <= 1'b1;
        end else if (char_ready) begin
            char_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tune_busy <= 1'b0;
        end else begin
            tune_busy <= pend_reg | tune_req | (item_reg == nsf_pkg::IT_TUNE);
        end
    end
endmodule
`default_nettype wire

// ---- bench/nsf_checker.sv ----
// Stream and field checks for the item formatter
`timescale 1ns/1ps
`default_nettype none
module nsf_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       tune_req,
    input wire logic       char_ready,
    input wire logic [7:0] char_data,
    input wire logic       char_valid,
    input wire logic       tune_busy
);
    logic       tk;
    logic [7:0] des_reg;
    logic [4:0] idx_reg;
    assign tk = char_valid && char_ready;
    // Last a, j, q or t designator and field position
    always_ff @(posedge clk) begin
        if (rst) begin
            des_reg <= 8'h00;
            idx_reg <= 5'h1F;
        end else if (tk) begin
            idx_reg <= idx_reg + {4'h0, idx_reg != 5'h1F};
            if (char_data inside {8'h61, 8'h6A, 8'h71, 8'h74}) begin
                des_reg <= char_data;
                idx_reg <= 5'h01;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_reset_quiet: assert property ($fell(rst) |->
        char_data == 8'h2D ##0 !char_valid [*8]) else $error("early char");
    chk_tune_flag: assert property (tune_req |=> tune_busy)
        else $error("tuning not pending");
    chk_tune_slot: assert property ($rose(tune_busy) |->
        ##[1:400] (tk && char_data == 8'h71)) else $error("tuning late");
    chk_q_pending: assert property (tk && char_data == 8'h71 |->
        tune_busy) else $error("tuning item unrequested");
    chk_stall_hold: assert property (char_valid && !char_ready |=>
        char_valid && $stable(char_data)) else $error("char lost");
    chk_alt_sign: assert property (tk && des_reg == 8'h61 &&
        idx_reg == 5'h01 |-> char_data inside {8'h2B, 8'h2D})
        else $error("bad altitude sign");
    chk_utc_colon: assert property (tk && des_reg == 8'h6A &&
        idx_reg inside {5'h03, 5'h06} |-> char_data == 8'h3A)
        else $error("bad time separator");
    chk_disc_spare: assert property (tk && des_reg == 8'h74 &&
        idx_reg inside {[5'h06:5'h0A]} |-> char_data == 8'h2D)
        else $error("spare discrete not dashed");
    chk_tune_target: assert property (tk && des_reg == 8'h71 &&
        idx_reg == 5'h01 |-> char_data inside {8'h31, 8'h32})
        else $error("bad tuning target");
    cover property (tk && char_data == 8'h71);
    cover property (tk && des_reg == 8'h74 && idx_reg == 5'h0A);
    cover property (char_valid && !char_ready);
endmodule
bind nsf_formatter nsf_checker u_chk (.clk(clk), .rst(rst),
    .tune_req(tune_req), .char_ready(char_ready), .char_data(char_data),
    .char_valid(char_valid), .tune_busy(tune_busy));
`default_nettype wire

// ---- bench/nsf_sink.sv ----
// Serial sender model, stalls one cycle in four
`timescale 1ns/1ps
`default_nettype none
module nsf_sink (
    input  wire logic clk,
    input  wire logic rst,
    output var logic  char_ready
);
    logic [1:0] cnt_reg;
    always_ff @(posedge clk) begin
        cnt_reg    <= rst ? 2'h0 : cnt_reg + 2'h1;
        char_ready <= !rst && cnt_reg != 2'h3;
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the item formatter
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, char_ready, char_valid, tune_busy, rst = 1'b1;
    logic enh_mode = 1'b1, pos_flag = 1'b0, nav_flag = 1'b0, lat_south = 1'b0;
    logic lon_west = 1'b1, xtk_right = 1'b1, course_selector_mode = 1'b0;
    logic var_west = 1'b1, alt_valid = 1'b1, alt_neg = 1'b0, tune_req = 1'b0;
    logic wpt_alert = 1'b1, turn_alert = 1'b0, msg_new = 1'b1, to_flag = 1'b1;
    logic msg_persist = 1'b0, from_flag = 1'b0, voice_radio_target = 1'b1;
    logic [6:0]  lat_deg = 7'h2D, lat_hund = 7'h0C, lon_hund = 7'h0C;
    logic [5:0]  lat_min = 6'h1E, lon_min = 6'h1E;
    logic [5:0]  utc_min = 6'h22, utc_sec = 6'h38;
    logic [7:0]  lon_deg = 8'h7A, char_data;
    logic [9:0]  trk_deg = 10'h02D, ground_speed_value = 10'h078;
    logic [19:0] dist_tenths = 20'h004D2, dest_tenths = 20'h0DDD5;
    logic [15:0] xtk_milli = 16'h04CE;
    logic [11:0] dtk_tenths = 12'h384, sel_course_tenths = 12'h0B4;
    logic [11:0] brg_tenths = 12'h708, radial_tenths = 12'h0C8;
    logic [11:0] var_tenths = 12'h019, epe_hundredths = 12'h190;
    logic [16:0] alt_ft = 17'h005DC, tune_khz = 17'h04844;
    logic [4:0]  utc_hour = 5'h0C;
    logic [1:0]  flight_phase = 2'h1, nav_mode = 2'h1;
    logic [2:0]  tune_sys = 3'h3;
    int          num_errors = 0;
    int          cmp_count = 0;
    string rows [14] = '{"AN 45 3012", "BW 122 3012", "C045", "D120",
        "E01234", "GR0123", "I0900", "L1800", "QW025", "T---A-----",
        "a+01500", "j12:34:56", "tWNTDT-----", "l056789"};
    string disc [4] = '{"tWNELT-----", "tTPTDF-----", "t--RO------",
        "tWNATT-----"};
    nsf_formatter DUT (.*);
    nsf_sink u_sink (.*);
    task automatic report_and_stop;
        $display("errors %0d of %0d compares", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic take(output logic [7:0] c);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(char_valid === 1'b1 && char_ready === 1'b1) && n < 400);
        c = char_data;
    endtask
    task automatic chk(input string e);
        logic [7:0] c;
        int i;
        i = 0;
        do begin
            take(c);
            i++;
        end while (c !== e[0] && i < 200);
        for (i = 1; i < e.len(); i++) begin
            take(c);
            check(c, e[i]);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        #10 rst = 1'b0;
        check(char_valid, 1'b0);
        check(char_data, 8'h2D);
        check(tune_busy, 1'b0);
        foreach (rows[r]) begin
            chk(rows[r]);
        end
        for (int k = 0; k < 4; k++) begin
            #10 flight_phase = k[1:0];
            nav_mode = k[1:0];
            wpt_alert = (k == 0 || k == 3);
            turn_alert = (k == 1 || k == 3);
            msg_new = wpt_alert;
            msg_persist = turn_alert;
            to_flag = wpt_alert;
            from_flag = turn_alert;
            chk(disc[k]);
        end
        #10 pos_flag = 1'b1;
        nav_flag = 1'b1;
        alt_ft = 17'h186A0;
        chk("D---");
        chk("E-----");
        chk("L----");
        chk("a------");
        #10 pos_flag = 1'b0;
        nav_flag = 1'b0;
        ground_speed_value = 10'h001;
        course_selector_mode = 1'b1;
        chk("C---");
        chk("I0180");
        chk("L2000");
        #10 enh_mode = 1'b0;
        chk("C045");
        chk("GR1230");
        @(posedge clk);
        #10 tune_req = 1'b1;
        @(posedge clk);
        #10 tune_req = 1'b0;
        check(tune_busy, 1'b1);
        chk("q1318500");
        report_and_stop();
    end
endmodule
`default_nettype wire
